// ### src/txpa_cfg.svh
`ifndef TXPA_CFG_SVH
`define TXPA_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TXPA_OFS_CTRL    4'h0
`define TXPA_OFS_STATUS  4'h4
`define TXPA_OFS_MASK    4'h8
`define TXPA_OFS_LEVEL   4'hC

// ****************************************************************
// control fields and reset value
// ****************************************************************
`define TXPA_CTRL_CKSEL  0
`define TXPA_CTRL_HALF   2
`define TXPA_CTRL_MODE   3
`define TXPA_CTRL_RST    5'h00
`define TXPA_MODE_LL     2'h0

// ****************************************************************
// status / mask bits and reset value
// ****************************************************************
`define TXPA_STS_OVF     0
`define TXPA_STS_UNF     2
`define TXPA_STS_ALIGN   4
`define TXPA_STS_W       5
`define TXPA_STS_RST     5'h00

// ****************************************************************
// level register fields
// ****************************************************************
`define TXPA_LVL_ERR     0
`define TXPA_LVL_ALIGN   2
`define TXPA_LVL_CNT_A   8
`define TXPA_LVL_CNT_B   16

// ****************************************************************
// timing and sizes
// ****************************************************************
`define TXPA_PRST_EDGES  2
`define TXPA_BUF_DEPTH   4

`endif

// ### src/txpa_pkg.sv
package txpa_pkg;

  typedef enum logic [1:0] {
    TXPA_CKSEL_LOW,
    TXPA_CKSEL_MID,
    TXPA_CKSEL_HIGH
  } txpa_cksel_t;

  typedef enum logic [1:0] {
    TXPA_PR_RUN,
    TXPA_PR_ARM,
    TXPA_PR_ALIGN
  } txpa_prst_t;

endpackage

// ### src/txpa_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// three-stage sampler, change accepted when stages two and three agree
// ****************************************************************
module txpa_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per bit: only a settled value is passed on
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= '0;
    end else if (clk_en) begin
      q_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
    end
  end

  assign q = q_ff;
endmodule

// ### src/txpa_buf.sv
`timescale 1ns/1ps
// ****************************************************************
// phase-align buffer storage, registered read data
// ****************************************************************
module txpa_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 4,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rd_data_ff;

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= '0;
    end else if (clk_en && rd_en) begin
      rd_data_ff <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;
endmodule

// ### src/txpa_top.sv
`timescale 1ns/1ps
`include "txpa_cfg.svh"
// Overview of operation
// RULE_01 - capture each channel's character on selected clock, forward onward
// RULE_02 - mode not LL: character goes to the encoder as data or command
// RULE_03 - mode LL: character is low bits of an unencoded 10-bit word
// RULE_04 - phase reset low: buffers re-centre their transfer timing
// RULE_05 - phase reset high: buffer phase stays fixed, normal operation
// RULE_06 - at half rate the phase reset only clears buffer faults; code also realigns the buffers then
// RULE_07 - characters may be dropped or repeated while realigning
// RULE_08 - host holds phase reset low for two reference rising edges
// RULE_09 - clock select low, full rate: buffer bypassed, reset ignored
// RULE_10 - host applies phase reset at start, after clocks and lock
// RULE_11 - half rate: inputs sampled, outputs updated on both edges
// RULE_12 - buffer over/underflow raises error until word sync or reset
// RULE_13 - clock select low/mid/high picks reference, own, channel A clock
// RULE_14 - host never selects half rate with clock select mid or high
// RULE_15 - two channels, own buffers, one shared phase reset
module txpa_top #(
  parameter int DEPTH = `TXPA_BUF_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        reference_clock,
  input  wire logic        tx_input_clock_a,
  input  wire logic        tx_input_clock_b,
  input  wire logic        tx_phase_reset_n,
  input  wire logic [7:0]  tx_char_in_a,
  input  wire logic [7:0]  tx_char_in_b,
  input  wire logic        tx_word_sync_sent,
  output logic      [7:0]  enc_char_a,
  output logic      [7:0]  enc_char_b,
  output logic             enc_valid_a,
  output logic             enc_valid_b,
  output logic      [9:0]  raw_char_a,
  output logic      [9:0]  raw_char_b,
  output logic             raw_valid_a,
  output logic             raw_valid_b,
  output logic             tx_error_flag_a,
  output logic             tx_error_flag_b
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic f_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic f_fall(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [4:0]                 ctrl_ff;
  logic [`TXPA_STS_W-1:0]     sts_ff;
  logic [`TXPA_STS_W-1:0]     mask_ff;
  logic [`TXPA_STS_W-1:0]     sts_set;
  logic                       ack_ff;
  logic [31:0]                rdata_ff;
  logic [31:0]                nxt_rdata;
  logic                       acc;
  logic                       wr_go;
  txpa_pkg::txpa_cksel_t      cksel;
  txpa_pkg::txpa_prst_t       pr_ff;
  txpa_pkg::txpa_prst_t       nxt_pr;
  logic                       half;
  logic                       bypass;
  logic [1:0]                 mode;
  logic [3:0]                 clk_f;
  logic [3:0]                 clk_prev_ff;
  logic [15:0]                dat_f;
  logic                       ref_rise;
  logic                       ref_fall;
  logic                       rd_tick;
  logic                       prst_low;
  logic                       aligning;
  logic                       align_done;
  logic [1:0]                 txclk_rise;
  logic [1:0]                 wr_stb;
  logic [1:0][7:0]            cap_data;
  logic [1:0][7:0]            buf_q;
  logic [1:0][AW-1:0]         wr_ptr_ff;
  logic [1:0][AW-1:0]         rd_ptr_ff;
  logic [1:0][AW:0]           cnt_ff;
  logic [1:0]                 primed_ff;
  logic [1:0]                 full;
  logic [1:0]                 empty;
  logic [1:0]                 do_wr;
  logic [1:0]                 do_rd;
  logic [1:0]                 ovf;
  logic [1:0]                 unf;
  logic [1:0]                 rd_pend_ff;
  logic [1:0][7:0]            out_char_ff;
  logic [1:0]                 out_vld_ff;
  logic [1:0]                 err_ff;

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  txpa_sync #(.W(4)) u_clk_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .d       ({tx_phase_reset_n, tx_input_clock_b,
               tx_input_clock_a, reference_clock}),
    .q       (clk_f)
  );

  txpa_sync #(.W(16)) u_dat_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .d       ({tx_char_in_b, tx_char_in_a}),
    .q       (dat_f)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_ff <= 4'h0;
    end else if (clk_en) begin
      clk_prev_ff <= clk_f;
    end
  end

  // ****************************************************************
  // clock selection and capture strobes
  // ****************************************************************
  assign cksel  = txpa_pkg::txpa_cksel_t'(ctrl_ff[`TXPA_CTRL_CKSEL +: 2]);
  assign half   = ctrl_ff[`TXPA_CTRL_HALF];
  assign mode   = ctrl_ff[`TXPA_CTRL_MODE +: 2];
  assign bypass = (cksel == txpa_pkg::TXPA_CKSEL_LOW) && !half; // RULE_09
  assign ref_rise      = f_rise(clk_f[0], clk_prev_ff[0]);
  assign ref_fall      = f_fall(clk_f[0], clk_prev_ff[0]);
  assign txclk_rise[0] = f_rise(clk_f[1], clk_prev_ff[1]);
  assign txclk_rise[1] = f_rise(clk_f[2], clk_prev_ff[2]);
  assign rd_tick  = ref_rise | (half & ref_fall); // RULE_11
  assign cap_data = dat_f;

  always_comb begin
    unique case (cksel) // RULE_13
      txpa_pkg::TXPA_CKSEL_LOW:  wr_stb = {2{rd_tick}}; // RULE_11
      txpa_pkg::TXPA_CKSEL_MID:  wr_stb = txclk_rise;
      txpa_pkg::TXPA_CKSEL_HIGH: wr_stb = {2{txclk_rise[0]}};
      default:                   wr_stb = 2'h0;
    endcase
  end

  // ****************************************************************
  // shared phase reset sequencing
  // ****************************************************************
  assign prst_low   = ref_rise && !clk_f[3] && !bypass; // RULE_09
  assign aligning   = (pr_ff == txpa_pkg::TXPA_PR_ALIGN); // RULE_15
  assign align_done = aligning && ref_rise && clk_f[3];

  always_comb begin
    nxt_pr = pr_ff;
    if (bypass) begin
      nxt_pr = txpa_pkg::TXPA_PR_RUN; // RULE_09
    end else if (ref_rise) begin
      unique case (pr_ff)
        txpa_pkg::TXPA_PR_RUN:
          nxt_pr = clk_f[3] ? pr_ff : txpa_pkg::TXPA_PR_ARM;
        txpa_pkg::TXPA_PR_ARM: // RULE_08
          nxt_pr = clk_f[3] ? txpa_pkg::TXPA_PR_RUN
                            : txpa_pkg::TXPA_PR_ALIGN;
        txpa_pkg::TXPA_PR_ALIGN: // RULE_05
          nxt_pr = clk_f[3] ? txpa_pkg::TXPA_PR_RUN : pr_ff;
        default:
          nxt_pr = txpa_pkg::TXPA_PR_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pr_ff <= txpa_pkg::TXPA_PR_RUN;
    end else if (clk_en) begin
      pr_ff <= nxt_pr;
    end
  end

  // ****************************************************************
  // phase-align buffers, one per channel
  // ****************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign full[c]  = (cnt_ff[c] == (AW+1)'(DEPTH));
    assign empty[c] = (cnt_ff[c] == '0);
    assign do_rd[c] = !bypass && !aligning && rd_tick && primed_ff[c]
                      && !empty[c];
    assign do_wr[c] = !bypass && !aligning && wr_stb[c]
                      && (!full[c] || do_rd[c]); // RULE_07
    assign ovf[c]   = !bypass && !aligning && wr_stb[c] && full[c]
                      && !do_rd[c];
    assign unf[c]   = !bypass && !aligning && rd_tick && primed_ff[c]
                      && empty[c];

    txpa_buf #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_buf (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .wr_en   (do_wr[c]),
      .wr_addr (wr_ptr_ff[c]),
      .wr_data (cap_data[c]), // RULE_01
      .rd_en   (do_rd[c]),
      .rd_addr (rd_ptr_ff[c]),
      .rd_data (buf_q[c])
    );
  end

  // pointers restart and refill to centre after each realignment
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
      primed_ff <= 2'h0;
    end else if (clk_en) begin
      for (int c = 0; c < 2; c++) begin
        if (aligning || bypass) begin // RULE_04
          wr_ptr_ff[c] <= '0;
          rd_ptr_ff[c] <= '0;
          cnt_ff[c]    <= '0;
          primed_ff[c] <= 1'b0;
        end else begin
          if (do_wr[c]) begin
            wr_ptr_ff[c] <= wr_ptr_ff[c] + AW'(1);
          end
          if (do_rd[c]) begin
            rd_ptr_ff[c] <= rd_ptr_ff[c] + AW'(1);
          end
          cnt_ff[c] <= cnt_ff[c] + (AW+1)'(do_wr[c])
                       - (AW+1)'(do_rd[c]);
          if (cnt_ff[c] >= (AW+1)'(DEPTH / 2)) begin
            primed_ff[c] <= 1'b1; // RULE_05
          end
        end
      end
    end
  end

  // ****************************************************************
  // character outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_ff  <= 2'h0;
      out_char_ff <= '0;
      out_vld_ff  <= 2'h0;
    end else if (clk_en) begin
      rd_pend_ff <= do_rd;
      for (int c = 0; c < 2; c++) begin
        if (bypass && wr_stb[c]) begin
          out_char_ff[c] <= cap_data[c]; // RULE_01
          out_vld_ff[c]  <= 1'b1;
        end else if (rd_pend_ff[c]) begin
          out_char_ff[c] <= buf_q[c];
          out_vld_ff[c]  <= 1'b1;
        end else begin
          out_vld_ff[c]  <= 1'b0;
        end
      end
    end
  end

  assign enc_char_a  = out_char_ff[0];
  assign enc_char_b  = out_char_ff[1];
  assign enc_valid_a = out_vld_ff[0] && (mode != `TXPA_MODE_LL); // RULE_02
  assign enc_valid_b = out_vld_ff[1] && (mode != `TXPA_MODE_LL); // RULE_02
  assign raw_char_a  = {2'h0, out_char_ff[0]}; // RULE_03
  assign raw_char_b  = {2'h0, out_char_ff[1]}; // RULE_03
  assign raw_valid_a = out_vld_ff[0] && (mode == `TXPA_MODE_LL);
  assign raw_valid_b = out_vld_ff[1] && (mode == `TXPA_MODE_LL);

  // ****************************************************************
  // error flags
  // ****************************************************************
  // faults are cleared by word sync sent, or by phase reset low unless the buffer is bypassed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_ff <= 2'h0;
    end else if (clk_en) begin
      for (int c = 0; c < 2; c++) begin
        if (ovf[c] || unf[c]) begin
          err_ff[c] <= 1'b1; // RULE_12
        end else if (tx_word_sync_sent || prst_low) begin
          err_ff[c] <= 1'b0; // RULE_06
        end
      end
    end
  end

  assign tx_error_flag_a = err_ff[0];
  assign tx_error_flag_b = err_ff[1];

  // ****************************************************************
  // register slave
  // ****************************************************************
  assign acc             = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_ff;
  assign wr_go           = avs_write & ack_ff;
  assign sts_set = {align_done, unf, ovf};

  always_comb begin
    unique case (avs_address)
      `TXPA_OFS_CTRL:   nxt_rdata = 32'(ctrl_ff);
      `TXPA_OFS_STATUS: nxt_rdata = 32'(sts_ff);
      `TXPA_OFS_MASK:   nxt_rdata = 32'(mask_ff);
      `TXPA_OFS_LEVEL:  nxt_rdata = (32'(err_ff) << `TXPA_LVL_ERR)
                        | (32'(aligning) << `TXPA_LVL_ALIGN)
                        | (32'(cnt_ff[0]) << `TXPA_LVL_CNT_A)
                        | (32'(cnt_ff[1]) << `TXPA_LVL_CNT_B);
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_ff <= acc & ~ack_ff;
      if (avs_read && !ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign avs_readdata = rdata_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `TXPA_CTRL_RST;
      mask_ff <= `TXPA_STS_RST;
    end else if (clk_en && wr_go) begin
      if (avs_address == `TXPA_OFS_CTRL) begin
        ctrl_ff <= avs_writedata[4:0];
      end
      if (avs_address == `TXPA_OFS_MASK) begin
        mask_ff <= avs_writedata[`TXPA_STS_W-1:0];
      end
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_ff <= `TXPA_STS_RST;
    end else if (clk_en) begin
      if (wr_go && avs_address == `TXPA_OFS_STATUS) begin
        sts_ff <= (sts_ff & ~avs_writedata[`TXPA_STS_W-1:0]) | sts_set;
      end else begin
        sts_ff <= sts_ff | sts_set;
      end
    end
  end

  assign irq = |(sts_ff & mask_ff);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_cap_fwd;
    bypass && wr_stb[0] && clk_en |=>
      out_vld_ff[0] && out_char_ff[0] == $past(cap_data[0]);
  endproperty
  a_cap_fwd: assert property (p_cap_fwd) else $error("capture lost"); // RULE_01

  property p_enc_sel;
    out_vld_ff[1] && mode != `TXPA_MODE_LL |-> enc_valid_b && !raw_valid_b;
  endproperty
  a_enc_sel: assert property (p_enc_sel) else $error("encoder path"); // RULE_02

  property p_raw_word;
    raw_valid_a |-> raw_char_a[7:0] == enc_char_a && !enc_valid_a;
  endproperty
  a_raw_word: assert property (p_raw_word) else $error("raw path"); // RULE_03

  property p_align_clr;
    aligning && !rd_pend_ff[0] && clk_en |=>
      cnt_ff[0] == '0 && !primed_ff[1] && !out_vld_ff[0]
      ##0 !rd_pend_ff[0];
  endproperty
  a_align_clr: assert property (p_align_clr) else $error("realign"); // RULE_04

  property p_run_hold;
    pr_ff == txpa_pkg::TXPA_PR_RUN && clk_en && !prst_low |=>
      pr_ff == txpa_pkg::TXPA_PR_RUN;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("phase moved"); // RULE_05

  property p_two_edges;
    pr_ff == txpa_pkg::TXPA_PR_RUN && prst_low && clk_en |=>
      pr_ff == txpa_pkg::TXPA_PR_ARM;
  endproperty
  a_two_edges: assert property (p_two_edges) else $error("arm"); // RULE_08

  property p_bypass_ign;
    bypass && clk_en |=> pr_ff == txpa_pkg::TXPA_PR_RUN && cnt_ff[1] == '0;
  endproperty
  a_bypass_ign: assert property (p_bypass_ign) else $error("bypass"); // RULE_09

  property p_half_fall;
    half && cksel == txpa_pkg::TXPA_CKSEL_LOW && ref_fall |-> &wr_stb;
  endproperty
  a_half_fall: assert property (p_half_fall) else $error("half edge"); // RULE_11

  property p_err_set;
    (ovf[0] || unf[0]) && clk_en |=> err_ff[0] [*1] ##0 tx_error_flag_a;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag"); // RULE_12

  property p_ck_high;
    cksel == txpa_pkg::TXPA_CKSEL_HIGH && txclk_rise[0] |-> wr_stb == 2'h3;
  endproperty
  a_ck_high: assert property (p_ck_high) else $error("clock select"); // RULE_13

  c_bypass_cap: cover property (bypass && wr_stb[0] && clk_en);
  c_align_done: cover property (align_done && clk_en);
  c_overflow:   cover property (ovf[1] && clk_en);
  c_buf_read:   cover property (rd_pend_ff[0] ##1 enc_valid_a);
endmodule

// ### test/txpa_host.sv
`timescale 1ns/1ps
// ****************************************
// host side: reference, input clocks, data
// ****************************************
module txpa_host (
  input  wire logic       run_ref,
  input  wire logic       run_a,
  input  wire logic       run_b,
  input  wire logic       use_ref,
  input  wire logic       dual,
  output logic            reference_clock,
  output logic            tx_input_clock_a,
  output logic            tx_input_clock_b,
  output logic            tx_phase_reset_n,
  output logic [7:0]      tx_char_in_a,
  output logic [7:0]      tx_char_in_b
);
  logic ck;
  logic ckd;
  logic cap;
  logic ckq;
  initial begin
    ck = 1'b0;
    tx_phase_reset_n = 1'b1;
    tx_char_in_a = 8'h00;
    forever #200 ck = ~ck;
  end
  always @(ck) ckd <= #130 ck;
  always @(ck) ckq <= #100 ck;
  // stopped clocks stand low
  assign reference_clock  = ck & run_ref;
  assign tx_input_clock_a = ckd & run_a;
  assign tx_input_clock_b = ckd & run_b;
  assign cap = use_ref ? reference_clock : tx_input_clock_a;
  // data moves half a period away from capture edge
  always @(negedge cap) if (!dual) tx_char_in_a <= tx_char_in_a + 8'h01;
  // half rate: a new character for every reference edge
  always @(ckq) if (dual) tx_char_in_a <= tx_char_in_a + 8'h01;
  assign tx_char_in_b = tx_char_in_a ^ 8'h80;
  task automatic realign();
    tx_phase_reset_n = 1'b0;
    repeat (3) @(posedge reference_clock);
    tx_phase_reset_n = 1'b1;
  endtask
endmodule

// ### test/txpa_top_bench.sv
`timescale 1ns/1ps
module txpa_top_bench;
  logic        ref_clk, arst_n, rq, wr, wreq, irq, wsync, clr;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, rd;
  logic        rck, ika, ikb, prn, eva, evb, rva, rvb, efa, efb;
  logic [7:0]  cha, chb, ea, eb, la;
  logic [9:0]  ra, rb;
  logic        run_ref, run_a, run_b, use_ref, sa, dual;
  int          fail_count, checks, cyc, n_ea, n_ra, n_eb, n_rb, bad;
  txpa_top #(.DEPTH(4)) txpa_top_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1),
    .avs_address(adr), .avs_read(rq), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .irq(irq), .reference_clock(rck), .tx_input_clock_a(ika),
    .tx_input_clock_b(ikb), .tx_phase_reset_n(prn),
    .tx_char_in_a(cha), .tx_char_in_b(chb), .tx_word_sync_sent(wsync),
    .enc_char_a(ea), .enc_char_b(eb), .enc_valid_a(eva),
    .enc_valid_b(evb), .raw_char_a(ra), .raw_char_b(rb),
    .raw_valid_a(rva), .raw_valid_b(rvb), .tx_error_flag_a(efa),
    .tx_error_flag_b(efb));
  txpa_host txpa_host_i (
    .run_ref(run_ref), .run_a(run_a), .run_b(run_b), .use_ref(use_ref),
    .dual(dual),
    .reference_clock(rck), .tx_input_clock_a(ika),
    .tx_input_clock_b(ikb), .tx_phase_reset_n(prn),
    .tx_char_in_a(cha), .tx_char_in_b(chb));
  // ****************************************
  // output monitor and helpers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      n_ea <= 0;
      n_ra <= 0;
      n_eb <= 0;
      n_rb <= 0;
      bad <= 0;
      sa <= 1'b0;
    end else begin
      n_ea <= n_ea + int'(eva);
      n_ra <= n_ra + int'(rva);
      n_eb <= n_eb + int'(evb);
      n_rb <= n_rb + int'(rvb);
      if (eva | rva) begin
        sa <= 1'b1;
        la <= eva ? ea : ra[7:0];
        if (sa && (eva ? {2'h0, ea} : ra) !== {2'h0, la + 8'h01}) bad <= bad + 1;
      end
    end
  end
  task automatic end_sim();
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic win(input int n);
    return n >= 18 && n <= 21;
  endfunction
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic wq;
    adr <= a;
    wd <= d;
    wr <= w;
    rq <= ~w;
    forever begin
      @(negedge ref_clk);
      wq = wreq;
      rd = rdat;
      @(posedge ref_clk);
      if (wq === 1'b0) break;
    end
    wr <= 1'b0;
    rq <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic run(input logic pr);
    int t0;
    t0 = cyc;
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    if (pr) txpa_host_i.realign();
    while (cyc - t0 < 160) @(posedge ref_clk);
  endtask
  task automatic t_reg();
    rdc(4'h0, 32'h0);
    rdc(4'h4, 32'h0);
    rdc(4'h8, 32'h0);
    rdc(4'h2, 32'h0);
    av(1'b1, 4'h8, 32'h1F);
    rdc(4'h8, 32'h1F);
    av(1'b1, 4'h8, 32'h0);
  endtask
  task automatic t_byp();
    for (int m = 0; m < 4; m++) begin
      av(1'b1, 4'h0, 32'(m) << 3);
      run(m == 3);
      cmp(win(m == 0 ? n_ra : n_ea), 1'b1);
      cmp(m == 0 ? n_eb : n_rb, 0);
      cmp(bad, 0);
      cmp(efa, 1'b0);
    end
  endtask
  task automatic t_mid();
    use_ref <= 1'b0;
    av(1'b1, 4'h0, 32'h09);
    repeat (40) @(posedge ref_clk);
    txpa_host_i.realign();
    repeat (20) @(posedge ref_clk);
    av(1'b0, 4'h4, 32'h0);
    cmp(rd[4], 1'b1);
    cmp(irq, 1'b0);
    av(1'b1, 4'h8, 32'h10);
    cmp(irq, 1'b1);
    av(1'b1, 4'h4, 32'h1F);
    cmp(irq, 1'b0);
    run(1'b0);
    cmp(win(n_ea) & win(n_eb), 1'b1);
    cmp(bad, 0);
    rdc(4'h4, 32'h0);
  endtask
  task automatic t_unf();
    run_a <= 1'b0;
    repeat (120) @(posedge ref_clk);
    cmp({efa, efb}, 2'h2);
    av(1'b0, 4'h4, 32'h0);
    cmp(rd[2], 1'b1);
    run_ref <= 1'b0;
    repeat (20) @(posedge ref_clk);
    wsync <= 1'b1;
    @(posedge ref_clk);
    wsync <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp(efa, 1'b0);
    run_ref <= 1'b1;
    run_a <= 1'b1;
    repeat (40) @(posedge ref_clk);
    txpa_host_i.realign();
    repeat (40) @(posedge ref_clk);
    cmp(efa, 1'b0);
  endtask
  task automatic t_high();
    av(1'b1, 4'h0, 32'h0A);
    run_b <= 1'b0;
    repeat (40) @(posedge ref_clk);
    txpa_host_i.realign();
    repeat (40) @(posedge ref_clk);
    run(1'b0);
    cmp(win(n_eb), 1'b1);
    run_b <= 1'b1;
  endtask
  task automatic t_half();
    av(1'b1, 4'h0, 32'h0C);
    dual <= 1'b1;
    repeat (40) @(posedge ref_clk);
    txpa_host_i.realign();
    repeat (40) @(posedge ref_clk);
    run(1'b0);
    cmp(n_ea >= 36 && n_ea <= 42, 1'b1);
    cmp(bad, 0);
    cmp(efa, 1'b0);
  endtask
  // ****************************************
  // clock, reset, sequence, timeout
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    {arst_n, rq, wr, adr, wd, wsync} = '0;
    {run_ref, run_a, run_b, use_ref, clr} = 5'h1F;
    {fail_count, checks, cyc} = '0;
    dual = 1'b0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_reg();
    t_byp();
    t_mid();
    t_unf();
    t_high();
    t_half();
    end_sim();
  end
endmodule
